// [shared/cmd_power_cfg.svh]
`ifndef CMD_POWER_CFG_SVH
`define CMD_POWER_CFG_SVH
`define CMD_OFFSET 8'h04
`define PMC_OFFSET 8'h40
`define PMCSR_OFFSET 8'h44
`define CMD_IO_BIT 0
`define CMD_MEM_BIT 1
`define CMD_MASTER_BIT 2
`define CMD_RESET 16'h0000
`define PMC_COLD_WAKE_BIT 15
`define PMCSR_WAKE_EN_BIT 8
`define PMCSR_WAKE_STS_BIT 15
`define BOOT_CYCLES 8'h10
`define SLOW_DIV 4'h3
`endif

// [shared/cmd_power_pkg.sv]
package cmd_power_pkg;
	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_UNINIT = 2'b01,
		ST_INIT = 2'b11
	} power_level_t;
	typedef enum logic [1:0] {
		CYC_NONE = 2'b00,
		CYC_CFG = 2'b01,
		CYC_IO = 2'b10,
		CYC_MEM = 2'b11
	} cycle_kind_t;
endpackage

// [logic/aux_sync.sv]
`timescale 1ns/1ns
module aux_sync #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk, // pci clock
	input wire logic rst_n, // async reset
	input wire logic [WIDTH-1:0] async_in, // raw pins
	output logic [WIDTH-1:0] sync_out // synchronised
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	if (WIDTH < 1) begin
		$error("aux_sync width must be positive");
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= async_in;
			stage2_ff <= stage1_ff;
		end
	end
	assign sync_out = stage2_ff;
endmodule

// [logic/cmd_power_ctrl.sv]
// Function
// R1: io enable bit 0 gates io responses
// R2: memory enable bit 1 gates memory responses
// R3: master enable bit 2 gates initiation
// R4: zero command: only configuration cycles answered
// R5: low power until enables set
// R6: configuration stays live; bootstrap; clock slowed
// R7: aux without main rail: wake deasserted
// R8: state after aux return is undefined
// R9: platform keeps rails off after aux loss
// R10: platform holds aux off until power cycle
// R11: platform drops aux, then full power-up
// R12: clock-run and aux supply supported
// R13: io enable fixed zero without io
// R14: wake context survives bus reset
// R15: cold wake capability reads one
// R16: unimplemented enables read zero
`timescale 1ns/1ns
`include "cmd_power_cfg.svh"
module cmd_power_ctrl #(
	parameter bit HAS_IO = 1'b1, // card decodes io space
	parameter bit COLD_WAKE = 1'b1 // sets PMC cold wake bit; wake needs main rail
) (
	input wire logic sys_clk, // pci clock
	input wire logic rst_n, // pci reset, low active
	input wire logic aux_rst_n, // aux supply power-on reset
	input wire logic main_ok_pin, // main rail good pin
	input wire logic aux_ok_pin, // aux rail good pin
	input wire logic cfg_wr, // config write strobe
	input wire logic cfg_rd, // config read strobe
	input wire logic [7:0] cfg_addr, // config byte offset
	input wire logic [15:0] cfg_wdata, // config write data
	output logic [15:0] cfg_rdata, // config read data
	input wire logic [1:0] cycle_kind, // decoded bus cycle kind
	output logic target_ack, // claim this target cycle
	input wire logic master_req, // core wants the bus
	output logic master_grant, // core may initiate
	input wire logic wake_event, // core wake request
	output logic pme_out, // wake pin drive
	output logic pme_oe, // wake pin output enable
	output logic full_power, // initialised level
	output logic core_clk_en, // core clock enable
	input wire logic clkrun_in, // clock run pin in
	output logic clkrun_out, // clock run pin drive
	output logic clkrun_oe // clock run output enable
);
	logic [15:0] cmd_ff, nxt_cmd;
	cmd_power_pkg::power_level_t level_ff, nxt_level;
	logic [7:0] boot_ff, nxt_boot;
	logic [3:0] div_ff, nxt_div;
	logic wake_en_ff, nxt_wake_en;
	logic wake_sts_ff, nxt_wake_sts;
	logic [1:0] rails;
	logic clkrun_s;
	logic main_ok, aux_ok;
	logic [15:0] rdata_ff, nxt_rdata;
	logic [15:0] cmd_mask;

	aux_sync #(.WIDTH(2)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(aux_rst_n),
		.async_in({main_ok_pin, aux_ok_pin}),
		.sync_out(rails)
	);
	assign main_ok = rails[1];
	assign aux_ok = rails[0];

	logic [1:0] cr_ff;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// clock run pin idles high, so no false request after reset
			cr_ff <= 2'b11;
		end else begin
			cr_ff <= {cr_ff[0], clkrun_in};
		end
	end
	assign clkrun_s = cr_ff[1];

	// ====================
	// command register
	always_comb begin
		cmd_mask = 16'h0000;
		cmd_mask[`CMD_IO_BIT] = HAS_IO; // R13 R16
		cmd_mask[`CMD_MEM_BIT] = 1'b1;
		cmd_mask[`CMD_MASTER_BIT] = 1'b1;
	end
	always_comb begin
		nxt_cmd = cmd_ff;
		if (cfg_wr && cfg_addr == `CMD_OFFSET) begin
			nxt_cmd = cfg_wdata & cmd_mask; // R16
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_ff <= `CMD_RESET; // R1 R2 R3
		end else begin
			cmd_ff <= nxt_cmd;
		end
	end

	// ====================
	// cycle gating
	always_comb begin
		case (cycle_kind)
			cmd_power_pkg::CYC_CFG: target_ack = 1'b1; // R4 R6
			cmd_power_pkg::CYC_IO: target_ack = cmd_ff[`CMD_IO_BIT]; // R1
			cmd_power_pkg::CYC_MEM: target_ack = cmd_ff[`CMD_MEM_BIT]; // R2
			default: target_ack = 1'b0;
		endcase
	end
	assign master_grant = master_req && cmd_ff[`CMD_MASTER_BIT] && level_ff == cmd_power_pkg::ST_INIT; // R3 R4

	// ====================
	// power level
	always_comb begin
		nxt_level = level_ff;
		nxt_boot = boot_ff;
		case (level_ff)
			cmd_power_pkg::ST_BOOT: begin
				if (boot_ff == `BOOT_CYCLES) begin
					nxt_level = cmd_power_pkg::ST_UNINIT; // R6
				end else begin
					nxt_boot = boot_ff + 8'h01;
				end
			end
			cmd_power_pkg::ST_UNINIT: begin
				if (|(cmd_ff & cmd_mask)) begin
					nxt_level = cmd_power_pkg::ST_INIT; // R5
				end
			end
			cmd_power_pkg::ST_INIT: begin
				if (~|cmd_ff) begin
					nxt_level = cmd_power_pkg::ST_UNINIT; // R5
				end
			end
			default: nxt_level = cmd_power_pkg::ST_BOOT;
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_ff <= cmd_power_pkg::ST_BOOT;
			boot_ff <= 8'h00;
		end else begin
			level_ff <= nxt_level;
			boot_ff <= nxt_boot;
		end
	end
	assign full_power = level_ff == cmd_power_pkg::ST_INIT;

	// ====================
	// reduced clock
	always_comb begin
		nxt_div = (div_ff == `SLOW_DIV) ? 4'h0 : div_ff + 4'h1;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= nxt_div;
		end
	end
	assign core_clk_en = full_power || div_ff == 4'h0; // R6

	// ====================
	// clock run: ask to keep clock while the pin reads low and a wake is pending or a master request is granted
	assign clkrun_out = 1'b0; // R12
	assign clkrun_oe = !clkrun_s && (master_grant || wake_sts_ff); // R12

	// ====================
	// wake context, on aux reset only
	always_comb begin
		nxt_wake_en = wake_en_ff;
		nxt_wake_sts = wake_sts_ff;
		if (cfg_wr && cfg_addr == `PMCSR_OFFSET) begin
			nxt_wake_en = cfg_wdata[`PMCSR_WAKE_EN_BIT];
			if (cfg_wdata[`PMCSR_WAKE_STS_BIT]) begin
				nxt_wake_sts = 1'b0; // R14
			end
		end
		if (wake_event && aux_ok) begin
			nxt_wake_sts = 1'b1;
		end
	end
	always_ff @(posedge sys_clk or negedge aux_rst_n) begin
		if (!aux_rst_n) begin
			wake_en_ff <= 1'b0; // R8 R14
			wake_sts_ff <= 1'b0;
		end else begin
			wake_en_ff <= nxt_wake_en;
			wake_sts_ff <= nxt_wake_sts;
		end
	end
	assign pme_out = 1'b0;
	assign pme_oe = wake_en_ff && wake_sts_ff && aux_ok && main_ok; // R7

	// ====================
	// config read data
	always_comb begin
		nxt_rdata = rdata_ff;
		if (cfg_rd) begin
			case (cfg_addr)
				`CMD_OFFSET: nxt_rdata = cmd_ff & cmd_mask; // R16
				`PMC_OFFSET: begin
					nxt_rdata = 16'h0000;
					nxt_rdata[`PMC_COLD_WAKE_BIT] = COLD_WAKE; // R15
				end
				`PMCSR_OFFSET: begin
					nxt_rdata = 16'h0000;
					nxt_rdata[`PMCSR_WAKE_EN_BIT] = wake_en_ff;
					nxt_rdata[`PMCSR_WAKE_STS_BIT] = wake_sts_ff;
				end
				default: nxt_rdata = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end
	assign cfg_rdata = rdata_ff;
endmodule

// [tb/cmd_power_ctrl_sva.sv]
`timescale 1ns/1ns
module cmd_power_ctrl_sva #(
	parameter bit COLD_WAKE = 1'b1
) (
	input wire logic sys_clk, // clock
	input wire logic rst_n, // reset
	input wire logic cfg_wr, // write
	input wire logic cfg_rd, // read
	input wire logic [7:0] cfg_addr, // offset
	input wire logic [15:0] cfg_wdata, // wdata
	input wire logic [15:0] cfg_rdata, // rdata
	input wire logic [1:0] cycle_kind, // kind
	input wire logic target_ack, // ack
	input wire logic master_req, // req
	input wire logic master_grant, // grant
	input wire logic pme_out, // wake drive
	input wire logic pme_oe, // wake drive enable
	input wire logic main_ok_pin, // main rail pin
	input wire logic full_power, // level
	input wire logic core_clk_en // clock enable
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_CFG: assert property (cycle_kind == 2'h1 |-> target_ack) else $error("config cycle not claimed");
	AST_ZERO: assert property (cfg_wr && cfg_addr == 8'h04 && cfg_wdata == 16'h0000 ##1 cycle_kind[1] |-> !target_ack)
		else $error("claimed with zero command");
	AST_MEM: assert property (cfg_wr && cfg_addr == 8'h04 && cfg_wdata[1] ##1 cycle_kind == 2'h3 |-> target_ack)
		else $error("memory cycle not claimed");
	AST_GRANT: assert property (master_grant |-> master_req && full_power) else $error("grant without cause");
	AST_BOOT: assert property ($rose(rst_n) |-> !full_power [*8]) else $error("full power during boot");
	AST_PME: assert property (!pme_out) else $error("wake pin driven high");
	AST_PME_RAIL: assert property (!main_ok_pin [*3] |-> !pme_oe) else $error("wake driven without main rail");
	AST_SLOW: assert property (!full_power && core_clk_en ##1 !full_power |-> !core_clk_en)
		else $error("clock not slowed");
	AST_FULL: assert property (full_power |-> core_clk_en) else $error("clock gated at full power");
	AST_RSVD: assert property (cfg_rd && cfg_addr == 8'h04 |=> cfg_rdata[15:3] == 13'h0000)
		else $error("unused command bits set");
	AST_PMC: assert property (cfg_rd && cfg_addr == 8'h40 |=> cfg_rdata[15] == COLD_WAKE)
		else $error("cold wake bit wrong");
endmodule
bind cmd_power_ctrl cmd_power_ctrl_sva #(.COLD_WAKE(COLD_WAKE)) chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.cycle_kind(cycle_kind), .target_ack(target_ack), .master_req(master_req), .master_grant(master_grant),
	.pme_out(pme_out), .pme_oe(pme_oe), .main_ok_pin(main_ok_pin), .full_power(full_power),
	.core_clk_en(core_clk_en));

// [tb/host_model.sv]
`timescale 1ns/1ns
module host_model (
	input wire logic sys_clk, // clock
	input wire logic [15:0] cfg_rdata, // rdata
	input wire logic target_ack, // ack
	output logic cfg_wr, // write
	output logic cfg_rd, // read
	output logic [7:0] cfg_addr, // offset
	output logic [15:0] cfg_wdata, // wdata
	output logic [1:0] cycle_kind, // kind
	output logic main_ok, // main rail
	output logic aux_ok, // aux rail
	output logic aux_rst_n // aux reset
);
	initial begin
		{cfg_wr, cfg_rd, cycle_kind, main_ok, aux_ok, aux_rst_n} = '0;
		cfg_addr = 8'h00;
		cfg_wdata = 16'h0000;
	end
	// aux goes first, then aux reset release, then the main rail
	task automatic power_up();
		@(posedge sys_clk) #5;
		aux_ok = 1'b1;
		repeat (2) @(posedge sys_clk);
		#5 aux_rst_n = 1'b1;
		repeat (2) @(posedge sys_clk);
		#5 main_ok = 1'b1;
	endtask
	task automatic set_main(input logic m);
		@(posedge sys_clk) #5;
		main_ok = m;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		@(posedge sys_clk) #5;
		{cfg_wr, cfg_rd} = {w, !w};
		cfg_addr = a;
		cfg_wdata = d;
		@(posedge sys_clk) #5;
		{cfg_wr, cfg_rd} = 2'b00;
		q = cfg_rdata;
		cfg_addr = ~a;
		cfg_wdata = ~d;
	endtask
	task automatic probe(input logic [1:0] k, output logic a);
		// kind stands across the next edge so the checker sees it
		cycle_kind = k;
		#1 a = target_ack;
		@(posedge sys_clk) #5;
	endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cfg_wr, cfg_rd, target_ack, master_grant, pme_out, pme_oe, full_power, core_clk_en, clkrun_out, clkrun_oe;
	logic main_ok, aux_ok, aux_rst_n, ack;
	logic master_req = 1'b0;
	logic wake_event = 1'b0;
	logic clkrun_in = 1'b1;
	logic [7:0] cfg_addr;
	logic [15:0] cfg_wdata, cfg_rdata, q;
	logic [1:0] cycle_kind;
	int error_cnt = 0;
	int total_checks = 0;
	initial forever #25 sys_clk = ~sys_clk;
	host_model host (.sys_clk(sys_clk), .cfg_rdata(cfg_rdata), .target_ack(target_ack), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cycle_kind(cycle_kind), .main_ok(main_ok),
		.aux_ok(aux_ok), .aux_rst_n(aux_rst_n));
	cmd_power_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .aux_rst_n(aux_rst_n), .main_ok_pin(main_ok),
		.aux_ok_pin(aux_ok), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cycle_kind(cycle_kind), .target_ack(target_ack), .master_req(master_req),
		.master_grant(master_grant), .wake_event(wake_event), .pme_out(pme_out), .pme_oe(pme_oe),
		.full_power(full_power), .core_clk_en(core_clk_en), .clkrun_in(clkrun_in), .clkrun_out(clkrun_out),
		.clkrun_oe(clkrun_oe));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#100000 error_cnt++;
		complete_run();
	end
	initial begin
		host.power_up();
		repeat (2) @(posedge sys_clk);
		#5 rst_n = 1'b1;
		host.probe(2'h1, ack);
		chk(ack, 16'h0001);
		host.probe(2'h3, ack);
		chk(ack, 16'h0000);
		host.xfer(1'b0, 8'h04, 16'h0000, q);
		chk(q, 16'h0000);
		repeat (20) @(posedge sys_clk);
		#5 chk(full_power, 16'h0000);
		master_req = 1'b1;
		wake_event = 1'b1;
		host.xfer(1'b1, 8'h04, 16'hffff, q);
		host.xfer(1'b0, 8'h04, 16'h0000, q);
		chk(q, 16'h0007);
		chk(full_power, 16'h0001);
		chk(master_grant, 16'h0001);
		chk(clkrun_out, 16'h0000);
		chk(clkrun_oe, 16'h0000);
		clkrun_in = 1'b0;
		repeat (2) @(posedge sys_clk);
		#5 chk(clkrun_oe, 16'h0001);
		host.probe(2'h2, ack);
		chk(ack, 16'h0001);
		host.probe(2'h3, ack);
		chk(ack, 16'h0001);
		host.xfer(1'b1, 8'h04, 16'h0000, q);
		host.probe(2'h2, ack);
		chk(ack, 16'h0000);
		host.probe(2'h1, ack);
		chk(ack, 16'h0001);
		#1 chk(master_grant, 16'h0000);
		host.xfer(1'b0, 8'h40, 16'h0000, q);
		chk(q[15], 16'h0001);
		host.xfer(1'b1, 8'h44, 16'h0100, q);
		@(posedge sys_clk) #5 rst_n = 1'b0;
		@(posedge sys_clk) #5 rst_n = 1'b1;
		host.xfer(1'b0, 8'h44, 16'h0000, q);
		chk(q[8], 16'h0001);
		chk(pme_oe, 16'h0001);
		chk(pme_out, 16'h0000);
		host.set_main(1'b0);
		repeat (2) @(posedge sys_clk);
		#5 chk(pme_oe, 16'h0000);
		host.xfer(1'b0, 8'h44, 16'h0000, q);
		chk(q[15], 16'h0001);
		complete_run();
	end
endmodule
